// ---- pkg/acs_pkg.sv ----
`default_nettype none
package acs_pkg;

    // Register offsets on page 0 of the control bus.
    localparam logic [7:0] ADDR_RESERVED_A  = 8'h2E;
    localparam logic [7:0] ADDR_LIVE_STATUS = 8'h2F;
    localparam logic [7:0] ADDR_PIN_CTRL    = 8'h35;
    localparam logic [7:0] ADDR_SYNC_WINDOW = 8'h39;
    localparam logic [7:0] ADDR_SYNC_TARGET = 8'h3A;
    localparam logic [7:0] ADDR_GAIN_CTRL   = 8'h3B;
    localparam logic [7:0] ADDR_RESERVED_B  = 8'h3C;

    // Field positions.
    localparam int STAT_LEFT_NOISE_BIT  = 6;
    localparam int STAT_RIGHT_NOISE_BIT = 5;
    localparam int STAT_INT_STD_BIT     = 4;
    localparam int STAT_INT_AUX_BIT     = 3;
    localparam int SYNC_CUSTOM_BIT      = 7;
    localparam int GAIN_LEFT_LSB        = 4;
    localparam int GAIN_RIGHT_LSB       = 0;

    // Reset values.
    localparam logic [7:0] PIN_CTRL_RESET    = 8'h12;
    localparam logic [7:0] SYNC_WINDOW_RESET = 8'h00;
    localparam logic [7:0] SYNC_TARGET_RESET = 8'h00;
    localparam logic [7:0] GAIN_CTRL_RESET   = 8'h44;
    localparam logic [7:0] READ_ZERO         = 8'h00;

    // Gain code limits and the reference oversampling ratio (64 = 2**6).
    localparam logic [3:0] GAIN_CODE_MAX  = 4'hC;
    localparam logic [3:0] GAIN_CODE_AUTO = 4'hF;
    localparam logic [3:0] GAIN_CODE_UNIT = 4'h4;
    localparam logic [3:0] ADC_OVERSAMPLING_RATIO_REF_LOG2  = 4'h6;

    // Filter mode codes.
    localparam logic [4:0] MODE_PROGRAMMABLE = 5'h00;
    localparam logic [4:0] MODE_FIXED_LAST   = 5'h12;
    localparam logic [4:0] MODE_UNITY_LAST   = 5'h06;

    // Output pin source selection.
    typedef enum logic [2:0] {
        SEL_OFF      = 3'b000,
        SEL_PRIMARY  = 3'b001,
        SEL_GPO      = 3'b010,
        SEL_CLOCK    = 3'b011,
        SEL_INT_ONE  = 3'b100,
        SEL_INT_TWO  = 3'b101,
        SEL_SEC_BCLK = 3'b110,
        SEL_SEC_WCLK = 3'b111
    } acs_pin_sel_t;

    // Layout of the output pin control register.
    typedef struct packed {
        logic [2:0]   rsvd;
        logic         keeper_off;
        acs_pin_sel_t sel;
        logic         gpo;
    } acs_pin_ctrl_t;

    // Signals that the pin mux can route out.
    typedef struct packed {
        logic primary_data;
        logic clock_output;
        logic interrupt_line_one;
        logic interrupt_line_two;
        logic sec_bit_clock;
        logic sec_word_clock;
    } acs_pin_src_t;

endpackage
`default_nettype wire

// ---- rtl/acs_cic_gain.sv ----
`default_nettype none
module acs_cic_gain
(
    input  wire logic               CLK,
    input  wire logic               RSTN,
    input  wire logic [3:0]         code,
    input  wire logic [3:0]         adc_oversampling_ratio_log2,
    input  wire logic [3:0]         decim_log2,
    input  wire logic [4:0]         filter_mode,
    output logic signed [7:0]       gain_exp,
    output logic                    code_bad
);
    import acs_pkg::*;

    logic signed [7:0] gain_exp_reg;
    logic signed [7:0] gain_exp_next;
    logic              code_bad_reg;
    logic              code_bad_next;
    logic signed [7:0] ratio_term;
    logic signed [7:0] base_term;
    logic              fixed_ref;

    // Gain is a power of two; the exponent is 4*log2(adc_oversampling_ratio/(64*dec)) plus the code.
    always_comb
    begin
        ratio_term    = $signed({4'h0, adc_oversampling_ratio_log2}) - $signed({4'h0, ADC_OVERSAMPLING_RATIO_REF_LOG2})
                        - $signed({4'h0, decim_log2});
        fixed_ref     = (adc_oversampling_ratio_log2 == ADC_OVERSAMPLING_RATIO_REF_LOG2) && (filter_mode != MODE_PROGRAMMABLE)
                        && (filter_mode <= MODE_UNITY_LAST);
        // At the reference ratio the first fixed blocks make the unit code exactly unity.
        base_term     = fixed_ref ? -$signed({4'h0, GAIN_CODE_UNIT}) : (ratio_term <<< 2);
        code_bad_next = 1'b0;
        if (code == GAIN_CODE_AUTO)
            gain_exp_next = 8'sh00;
        else if (code > GAIN_CODE_MAX)
        begin
            // Codes 13 and 14 have no defined gain, so they are held at the top code.
            gain_exp_next = base_term + $signed({4'h0, GAIN_CODE_MAX});
            code_bad_next = 1'b1;
        end
        else
            gain_exp_next = base_term + $signed({4'h0, code});
    end

    // Result register.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            gain_exp_reg <= 8'sh00;
            code_bad_reg <= 1'b0;
        end
        else
        begin
            gain_exp_reg <= gain_exp_next;
            code_bad_reg <= code_bad_next;
        end
    end

    assign gain_exp = gain_exp_reg;
    assign code_bad = code_bad_reg;

    property p_gain_unit;
        @(posedge CLK) disable iff (!RSTN)
        (code == GAIN_CODE_UNIT && adc_oversampling_ratio_log2 == ADC_OVERSAMPLING_RATIO_REF_LOG2
            && filter_mode inside {[5'h01:MODE_UNITY_LAST]})
        |=> gain_exp == 8'sh00;
    endproperty
    a_gain_unit: assert property (p_gain_unit) else $error("unit gain code not unity");

    property p_gain_auto;
        @(posedge CLK) disable iff (!RSTN)
        (code == GAIN_CODE_AUTO) |=> (gain_exp == 8'sh00 && !code_bad);
    endproperty
    a_gain_auto: assert property (p_gain_auto) else $error("auto gain not unity");

endmodule
`default_nettype wire

// ---- rtl/acs_instr_sync.sv ----
`default_nettype none
module acs_instr_sync
(
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       frame_start,
    input  wire logic       instr_step,
    input  wire logic       reset_disable,
    input  wire logic       custom_en,
    input  wire logic [6:0] window_half,
    input  wire logic [8:0] target,
    output logic [8:0]      count,
    output logic            hit
);
    import acs_pkg::*;

    logic [8:0] count_reg;
    logic [8:0] count_next;
    logic       hit_reg;
    logic       hit_next;

    // Distance between two instruction indices.
    function automatic logic [8:0] dist_f(input logic [8:0] a, input logic [8:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    // Frame start wins over a step so a frame begins at instruction 0 unless reset_disable is set.
    always_comb
    begin
        count_next = count_reg;
        if (frame_start && !reset_disable)
            count_next = 9'h000;
        else if (instr_step)
            count_next = count_reg + 9'h001;
        // Custom mode accepts +/-N around the target; default mode syncs at 0.
        if (custom_en)
            hit_next = dist_f(count_reg, target) <= {2'b00, window_half};
        else
            hit_next = (count_reg == 9'h000);
    end

    // Counter and window flag registers.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            count_reg <= 9'h000;
            hit_reg   <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            hit_reg   <= hit_next;
        end
    end

    assign count = count_reg;
    assign hit   = hit_reg;

    property p_frame_reset;
        @(posedge CLK) disable iff (!RSTN)
        (frame_start && !reset_disable) |=> count == 9'h000;
    endproperty
    a_frame_reset: assert property (p_frame_reset) else $error("counter not reset");

    property p_window_zero;
        @(posedge CLK) disable iff (!RSTN)
        (custom_en && window_half == 7'h00 && count != target) |=> !hit;
    endproperty
    a_window_zero: assert property (p_window_zero) else $error("zero window hit");

endmodule
`default_nettype wire

// ---- rtl/acs_regs.sv ----
// Contract
// - Status bit 6 reads 1 while left power is below left noise threshold.
// - Status bit 5 reads 1 while right power is below right noise threshold.
// - Status bit 4 shows the live standard engine interrupt at read time.
// - Status bit 3 shows the live auxiliary engine interrupt at read time.
// - Pin control bit 4 low enables the bus keeper; resets high.
// - Three-bit select routes the serial output pin among eight sources; the code uses select 000 to turn the pin off, leaving seven sources.
// - With select 010 the pin drives pin control bit 0, reset 0.
// - Sync bit 7 picks default or custom counter synchronization; resets 0.
// - Window field N gives a window of plus or minus N instructions.
// - Target field M places the sync target at instruction 2M.
// - Gain register holds left code high, right code low, each reset 4.
// - Code 4 at ratio 64 with fixed modes gives unity gain; the code does this for modes 1 to 6 only.
// - Codes 0 to 12 give gain (ratio/64/decimation)^4 times 2^code.
// - Code 15 chooses gain automatically between one half and one; the code always gives unity (exponent 0).
// - Filter mode 0 is programmable, 1 to 18 fixed blocks, above reserved.
// - Instruction counter resets each frame unless reset-disable is set.
`default_nettype none
module acs_regs
(
    input  wire logic                 CLK,
    input  wire logic                 RSTN,
    input  wire logic [7:0]           REG_ADDR,
    input  wire logic [7:0]           REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output logic [7:0]                REG_RDATA,
    output logic                      REG_RVALID,
    input  wire logic                 LEFT_BELOW_NOISE,
    input  wire logic                 RIGHT_BELOW_NOISE,
    input  wire logic                 ENGINE_INT_STD,
    input  wire logic                 ENGINE_INT_AUX,
    input  wire acs_pkg::acs_pin_src_t PIN_SRC,
    output logic                      DOUT_O,
    output logic                      DOUT_OE,
    output logic                      KEEPER_EN,
    input  wire logic                 FRAME_START,
    input  wire logic                 INSTR_STEP,
    input  wire logic                 COUNTER_RESET_DISABLE,
    output logic [8:0]                INSTR_COUNT,
    output logic                      SYNC_HIT,
    input  wire logic [3:0]           ADC_OVERSAMPLING_RATIO_LOG2,
    input  wire logic [3:0]           DECIM_LOG2,
    input  wire logic [4:0]           FILTER_MODE,
    output logic                      PROG_INSTR_MODE,
    output logic [4:0]                FIXED_BLOCK_SEL,
    output logic                      MODE_RESERVED,
    output logic signed [7:0]         LEFT_GAIN_EXP,
    output logic signed [7:0]         RIGHT_GAIN_EXP,
    output logic                      LEFT_GAIN_BAD,
    output logic                      RIGHT_GAIN_BAD
);
    import acs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register bank.

    acs_pin_ctrl_t pin_reg;
    acs_pin_ctrl_t pin_next;
    logic [7:0]    win_reg;
    logic [7:0]    win_next;
    logic [7:0]    tgt_reg;
    logic [7:0]    tgt_next;
    logic [7:0]    gain_reg;
    logic [7:0]    gain_next;
    logic [7:0]    rdata_reg;
    logic [7:0]    rdata_next;
    logic          rvalid_reg;
    logic          rvalid_next;
    logic [7:0]    live_status;

    // Live status word; nothing here is latched, so a read cannot disturb it.
    always_comb
    begin
        live_status                       = READ_ZERO;
        live_status[STAT_LEFT_NOISE_BIT]  = LEFT_BELOW_NOISE;
        live_status[STAT_RIGHT_NOISE_BIT] = RIGHT_BELOW_NOISE;
        live_status[STAT_INT_STD_BIT]     = ENGINE_INT_STD;
        live_status[STAT_INT_AUX_BIT]     = ENGINE_INT_AUX;
    end

    // Write decode; only writable fields of mapped registers take data.
    always_comb
    begin
        pin_next  = pin_reg;
        win_next  = win_reg;
        tgt_next  = tgt_reg;
        gain_next = gain_reg;
        if (REG_WR)
        begin
            case (REG_ADDR)
                ADDR_PIN_CTRL:
                begin
                    // Upper bits stay zero even if software breaks the contract.
                    pin_next      = acs_pin_ctrl_t'(REG_WDATA);
                    pin_next.rsvd = 3'b000;
                end
                ADDR_SYNC_WINDOW: win_next  = REG_WDATA;
                ADDR_SYNC_TARGET: tgt_next  = REG_WDATA;
                ADDR_GAIN_CTRL:   gain_next = REG_WDATA;
                // Status and reserved offsets drop the write.
                default: pin_next = pin_reg;
            endcase
        end
    end

    // Read decode; reserved and unmapped offsets return zero.
    always_comb
    begin
        rvalid_next = REG_RD;
        rdata_next  = rdata_reg;
        if (REG_RD)
        begin
            case (REG_ADDR)
                ADDR_LIVE_STATUS: rdata_next = live_status;
                ADDR_PIN_CTRL:    rdata_next = pin_reg;
                ADDR_SYNC_WINDOW: rdata_next = win_reg;
                ADDR_SYNC_TARGET: rdata_next = tgt_reg;
                ADDR_GAIN_CTRL:   rdata_next = gain_reg;
                default:          rdata_next = READ_ZERO;
            endcase
        end
    end

    // Bank registers.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pin_reg    <= acs_pin_ctrl_t'(PIN_CTRL_RESET);
            win_reg    <= SYNC_WINDOW_RESET;
            tgt_reg    <= SYNC_TARGET_RESET;
            gain_reg   <= GAIN_CTRL_RESET;
            rdata_reg  <= READ_ZERO;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            pin_reg    <= pin_next;
            win_reg    <= win_next;
            tgt_reg    <= tgt_next;
            gain_reg   <= gain_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign REG_RDATA  = rdata_reg;
    assign REG_RVALID = rvalid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial output pin mux.

    logic dout_reg;
    logic dout_next;
    logic oe_reg;
    logic oe_next;

    // The pin is registered to keep glitches off it; this costs one cycle of
    // delay on routed clocks, which the downstream timing must allow for.
    always_comb
    begin
        oe_next = 1'b1;
        case (pin_reg.sel)
            SEL_OFF:
            begin
                dout_next = 1'b0;
                oe_next   = 1'b0;
            end
            SEL_PRIMARY:  dout_next = PIN_SRC.primary_data;
            SEL_GPO:      dout_next = pin_reg.gpo;
            SEL_CLOCK:    dout_next = PIN_SRC.clock_output;
            SEL_INT_ONE:  dout_next = PIN_SRC.interrupt_line_one;
            SEL_INT_TWO:  dout_next = PIN_SRC.interrupt_line_two;
            SEL_SEC_BCLK: dout_next = PIN_SRC.sec_bit_clock;
            SEL_SEC_WCLK: dout_next = PIN_SRC.sec_word_clock;
            default:
            begin
                dout_next = 1'b0;
                oe_next   = 1'b0;
            end
        endcase
    end

    // Pin registers; the buffer stays off through reset.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            dout_reg <= 1'b0;
            oe_reg   <= 1'b0;
        end
        else
        begin
            dout_reg <= dout_next;
            oe_reg   <= oe_next;
        end
    end

    assign DOUT_O    = dout_reg;
    assign DOUT_OE   = oe_reg;
    assign KEEPER_EN = !pin_reg.keeper_off;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction counter synchronization and filter mode decode.

    logic mode_prog_reg;
    logic mode_prog_next;
    logic mode_rsvd_reg;
    logic mode_rsvd_next;
    logic [4:0] block_reg;
    logic [4:0] block_next;

    acs_instr_sync u_sync
    (
        .CLK           (CLK),
        .RSTN          (RSTN),
        .frame_start   (FRAME_START),
        .instr_step    (INSTR_STEP),
        .reset_disable (COUNTER_RESET_DISABLE),
        .custom_en     (win_reg[SYNC_CUSTOM_BIT]),
        .window_half   (win_reg[6:0]),
        .target        ({tgt_reg, 1'b0}),
        .count         (INSTR_COUNT),
        .hit           (SYNC_HIT)
    );

    // Reserved mode codes select no block rather than wrapping onto one.
    always_comb
    begin
        mode_prog_next = (FILTER_MODE == MODE_PROGRAMMABLE);
        mode_rsvd_next = (FILTER_MODE > MODE_FIXED_LAST);
        block_next     = (mode_prog_next || mode_rsvd_next) ? 5'h00 : FILTER_MODE;
    end

    // Mode decode registers.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            mode_prog_reg <= 1'b0;
            mode_rsvd_reg <= 1'b0;
            block_reg     <= 5'h00;
        end
        else
        begin
            mode_prog_reg <= mode_prog_next;
            mode_rsvd_reg <= mode_rsvd_next;
            block_reg     <= block_next;
        end
    end

    assign PROG_INSTR_MODE = mode_prog_reg;
    assign MODE_RESERVED   = mode_rsvd_reg;
    assign FIXED_BLOCK_SEL = block_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decimator gain, one calculator per channel.

    acs_cic_gain u_gain_left
    (
        .CLK        (CLK),
        .RSTN       (RSTN),
        .code       (gain_reg[GAIN_LEFT_LSB +: 4]),
        .adc_oversampling_ratio_log2  (ADC_OVERSAMPLING_RATIO_LOG2),
        .decim_log2 (DECIM_LOG2),
        .filter_mode(FILTER_MODE),
        .gain_exp   (LEFT_GAIN_EXP),
        .code_bad   (LEFT_GAIN_BAD)
    );

    acs_cic_gain u_gain_right
    (
        .CLK        (CLK),
        .RSTN       (RSTN),
        .code       (gain_reg[GAIN_RIGHT_LSB +: 4]),
        .adc_oversampling_ratio_log2  (ADC_OVERSAMPLING_RATIO_LOG2),
        .decim_log2 (DECIM_LOG2),
        .filter_mode(FILTER_MODE),
        .gain_exp   (RIGHT_GAIN_EXP),
        .code_bad   (RIGHT_GAIN_BAD)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_status_read;
        REG_RD && REG_ADDR == ADDR_LIVE_STATUS;
    endsequence

    sequence s_pin_write;
        REG_WR && REG_ADDR == ADDR_PIN_CTRL;
    endsequence

    property p_left_noise;
        @(posedge CLK) disable iff (!RSTN)
        s_status_read |=> REG_RDATA[STAT_LEFT_NOISE_BIT] == $past(LEFT_BELOW_NOISE);
    endproperty
    a_left_noise: assert property (p_left_noise) else $error("left noise bit wrong");

    property p_right_noise;
        @(posedge CLK) disable iff (!RSTN)
        s_status_read |=> REG_RDATA[STAT_RIGHT_NOISE_BIT] == $past(RIGHT_BELOW_NOISE);
    endproperty
    a_right_noise: assert property (p_right_noise) else $error("right noise bit wrong");

    property p_int_live;
        @(posedge CLK) disable iff (!RSTN)
        s_status_read |=> REG_RVALID && REG_RDATA[4:3] == $past({ENGINE_INT_STD, ENGINE_INT_AUX});
    endproperty
    a_int_live: assert property (p_int_live) else $error("interrupt bits wrong");

    property p_keeper;
        @(posedge CLK) disable iff (!RSTN)
        s_pin_write |=> KEEPER_EN == !$past(REG_WDATA[4]);
    endproperty
    a_keeper: assert property (p_keeper) else $error("keeper control wrong");

    property p_pin_off;
        @(posedge CLK) disable iff (!RSTN)
        (pin_reg.sel == SEL_OFF) |=> !DOUT_OE;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin driven while off");

    property p_gpo;
        @(posedge CLK) disable iff (!RSTN)
        (pin_reg.sel == SEL_GPO) |=> DOUT_OE && DOUT_O == $past(pin_reg.gpo);
    endproperty
    a_gpo: assert property (p_gpo) else $error("gpo level wrong");

    property p_ro_write;
        @(posedge CLK) disable iff (!RSTN)
        (REG_WR && REG_ADDR == ADDR_LIVE_STATUS)
        |=> $stable(pin_reg) && $stable(win_reg) && $stable(tgt_reg) && $stable(gain_reg);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write took");

    property p_pin_rsvd;
        @(posedge CLK) disable iff (!RSTN)
        (REG_RD && REG_ADDR == ADDR_PIN_CTRL) |=> REG_RDATA[7:5] == 3'b000;
    endproperty
    a_pin_rsvd: assert property (p_pin_rsvd) else $error("reserved pin bits set");

endmodule
`default_nettype wire

// ---- sim/acs_host.sv ----
`default_nettype none
module acs_host
(
    input  wire logic       CLK,
    output logic [7:0]      REG_ADDR,
    output logic [7:0]      REG_WDATA,
    output logic            REG_WR,
    output logic            REG_RD
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////
    // The bus is idle and deselected from time zero.
    initial
    begin
        REG_ADDR  = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
    end
    // One write strobe; zeros go to reserved places except in refusal tests.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLK);
        REG_WR    <= 1'b0;
        REG_WDATA <= ~d; // The data lines no longer show the old byte once released.
    endtask
    // One read strobe; the answer is collected by the bench's monitor.
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CLK);
        REG_RD   <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- sim/acs_regs_tb.sv ----
`default_nettype none
module acs_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import acs_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, lbn = 1'b0, rbn = 1'b0, istd = 1'b0, iaux = 1'b0;
    logic fs = 1'b0, step = 1'b0, crd = 1'b0, rvalid, dout_o, dout_oe, keeper, hit;
    logic prog, mres, lbad, rbad, wr, rd;
    logic [7:0]        addr, wdata, rdata, v8;
    logic [3:0]        adc_oversampling_ratio = 4'h6, dec = 4'h0, v;
    logic [4:0]        mode = 5'h01, fsel;
    logic [8:0]        cnt;
    logic signed [7:0] lexp, rexp;
    acs_pin_src_t      src = '0;
    logic [7:0]        exp_q[$];
    int                n_mismatch = 0;
    int                n_checks = 0;
    ////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    acs_host host (.CLK(clk), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd));
    acs_regs uut (.CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .LEFT_BELOW_NOISE(lbn),
        .RIGHT_BELOW_NOISE(rbn), .ENGINE_INT_STD(istd), .ENGINE_INT_AUX(iaux), .PIN_SRC(src),
        .DOUT_O(dout_o), .DOUT_OE(dout_oe), .KEEPER_EN(keeper), .FRAME_START(fs),
        .INSTR_STEP(step), .COUNTER_RESET_DISABLE(crd), .INSTR_COUNT(cnt), .SYNC_HIT(hit),
        .ADC_OVERSAMPLING_RATIO_LOG2(adc_oversampling_ratio), .DECIM_LOG2(dec), .FILTER_MODE(mode),
        .PROG_INSTR_MODE(prog), .FIXED_BLOCK_SEL(fsel), .MODE_RESERVED(mres),
        .LEFT_GAIN_EXP(lexp), .RIGHT_GAIN_EXP(rexp), .LEFT_GAIN_BAD(lbad), .RIGHT_GAIN_BAD(rbad));
    ////////////////////////////////////////////////////////////
    // Every comparison goes through here so that unknowns never pass.
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] want);
        n_checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A read notes its expected byte before the strobe goes out.
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int k, input logic frame);
        @(posedge clk);
        if (frame) fs <= 1'b1;
        else step <= 1'b1;
        repeat (k) @(posedge clk);
        fs <= 1'b0;
        step <= 1'b0;
    endtask
    // Gain exponent: code 15 picks unity, codes above 12 clamp, else the ratio formula.
    function automatic logic [8:0] gexp(input logic [3:0] c);
        if (c == 4'hF) return 9'h000;
        return 9'(4 * (int'(adc_oversampling_ratio) - 6 - int'(dec)) + (c > 4'hC ? 12 : int'(c)));
    endfunction
    // Read data is checked against the oldest note whenever a valid pulse shows.
    always @(negedge clk)
        if (rvalid === 1'b1)
        begin
            if (exp_q.size() == 0) chk("unasked read", 9'h1, 9'h0);
            else chk("read data", {1'b0, rdata}, {1'b0, exp_q.pop_front()});
        end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
    ////////////////////////////////////////////////////////////
    // Main sequence: reset values, status, pin mux, refusals, sync, gain, modes.
    initial
    begin
        void'($urandom(32'h5FF7FF68));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        settle(2);
        chk("unity gain", {1'b0, lexp}, 9'h000);
        rdx(ADDR_PIN_CTRL, 8'h12);
        rdx(ADDR_SYNC_WINDOW, 8'h00);
        rdx(ADDR_SYNC_TARGET, 8'h00);
        rdx(ADDR_GAIN_CTRL, 8'h44);
        repeat (8)
        begin
            v = 4'($urandom);
            @(posedge clk);
            {lbn, rbn, istd, iaux} <= v;
            rdx(ADDR_LIVE_STATUS, {1'b0, v, 3'b000});
            rdx(ADDR_LIVE_STATUS, {1'b0, v, 3'b000});
        end
        for (int s = 0; s < 8; s++)
        begin
            v8 = 8'($urandom);
            @(posedge clk);
            src <= acs_pin_src_t'(v8[5:0]);
            host.wr(ADDR_PIN_CTRL, {3'b000, v8[6], 3'(s), v8[7]});
            settle(3);
            chk("keeper", {8'h00, keeper}, {8'h00, ~v8[6]});
            chk("drive", {8'h00, dout_oe}, {8'h00, s != 0});
            if (s != 0) chk("pin", {8'h00, dout_o},
                {8'h00, s == 1 ? v8[5] : s == 2 ? v8[7] : v8[7 - s]});
            rdx(ADDR_PIN_CTRL, {3'b000, v8[6], 3'(s), v8[7]});
        end
        host.wr(ADDR_PIN_CTRL, 8'hFF);
        host.wr(ADDR_LIVE_STATUS, 8'hFF);
        host.wr(ADDR_RESERVED_A, 8'h5A);
        host.wr(ADDR_RESERVED_B, 8'hA5);
        rdx(ADDR_PIN_CTRL, 8'h1F);
        rdx(ADDR_RESERVED_A, 8'h00);
        rdx(ADDR_RESERVED_B, 8'h00);
        pulse(1, 1'b1);
        pulse(5, 1'b0);
        crd <= 1'b1;
        pulse(1, 1'b1);
        settle(2);
        chk("count", cnt, 9'h005);
        chk("hit", {8'h00, hit}, 9'h000);
        host.wr(ADDR_SYNC_WINDOW, 8'h81);
        host.wr(ADDR_SYNC_TARGET, 8'h03);
        settle(2);
        chk("hit", {8'h00, hit}, 9'h001);
        pulse(2, 1'b0);
        settle(2);
        chk("hit", {8'h00, hit}, 9'h001);
        pulse(1, 1'b0);
        settle(2);
        chk("hit", {8'h00, hit}, 9'h000);
        rdx(ADDR_SYNC_WINDOW, 8'h81);
        crd <= 1'b0;
        host.wr(ADDR_SYNC_WINDOW, 8'h01);
        pulse(1, 1'b1);
        settle(2);
        chk("count", cnt, 9'h000);
        chk("hit", {8'h00, hit}, 9'h001);
        host.wr(ADDR_SYNC_WINDOW, 8'h80);
        settle(2);
        chk("hit", {8'h00, hit}, 9'h000);
        for (int i = 0; i < 6; i++)
        begin
            v8 = (i < 4) ? 8'($urandom) : (i == 4 ? 8'hFD : 8'hEC);
            @(posedge clk);
            mode <= 5'h00;
            dec <= 4'(i & 1);
            host.wr(ADDR_GAIN_CTRL, v8);
            settle(3);
            chk("left gain", {lexp[7], lexp}, gexp(v8[7:4]));
            chk("right gain", {rexp[7], rexp}, gexp(v8[3:0]));
            chk("left bad", {8'h00, lbad}, {8'h00, v8[7:4] inside {4'hD, 4'hE}});
            chk("right bad", {8'h00, rbad}, {8'h00, v8[3:0] inside {4'hD, 4'hE}});
        end
        for (int m = 0; m < 32; m++)
        begin
            @(posedge clk);
            mode <= 5'(m);
            settle(2);
            chk("prog", {8'h00, prog}, {8'h00, m == 0});
            chk("block", {4'h0, fsel}, (m >= 1 && m <= 18) ? 9'(m) : 9'h000);
            chk("reserved mode", {8'h00, mres}, {8'h00, m > 18});
        end
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
        if (exp_q.size() > 0) n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
